// ===== src/hlcs_pkg.sv
// Function
// - reserved control bits 21 and 20 read as zero
// - link power status 1 permits link-PHY talk, 0 blocks it
// - access to PHY-clock registers while that clock stops gives target abort
// - with target abort disabled such accesses return all ones instead
// - offsets DCh to F0h and 100h to 11Ch sit in PHY-clock domain
// - posted writes accepted only while posted-write enable is 1
// - hardware or software reset clears link enable
// - link enable 0 disconnects the link: no receive, process or transmit
// - soft reset restores state and registers, flushes FIFOs, not config
// - soft reset bit reads 1 while reset runs, clears itself when done
// - self-ID base holds bits 31 to 11, bits 10 to 0 read zero
// - control flags have a set view at 50h and clear view at 54h
package hlcs_pkg;

  // register offsets
  localparam logic [11:0] HLCS_OFS_CTRL_SET = 12'h050;
  localparam logic [11:0] HLCS_OFS_CTRL_CLR = 12'h054;
  localparam logic [11:0] HLCS_OFS_SIDB     = 12'h064;
  localparam logic [11:0] HLCS_PHY_LO1      = 12'h0DC;
  localparam logic [11:0] HLCS_PHY_HI1      = 12'h0F0;
  localparam logic [11:0] HLCS_PHY_LO2      = 12'h100;
  localparam logic [11:0] HLCS_PHY_HI2      = 12'h11C;

  // field positions in the control word and the self-ID base
  localparam int unsigned HLCS_BIT_NOSWAP = 30;
  localparam int unsigned HLCS_BIT_PROG   = 23;
  localparam int unsigned HLCS_BIT_ENH    = 22;
  localparam int unsigned HLCS_BIT_LPS    = 19;
  localparam int unsigned HLCS_BIT_PWE    = 18;
  localparam int unsigned HLCS_BIT_LE     = 17;
  localparam int unsigned HLCS_BIT_SRST   = 16;
  localparam int unsigned HLCS_SIDB_LSB   = 11;

  // values after reset, the all-ones answer and cycle counts
  localparam logic [20:0] HLCS_SIDB_RST    = 21'h000000;
  localparam logic [31:0] HLCS_ALL_ONES    = 32'hFFFFFFFF;
  localparam int unsigned HLCS_SRST_CYCLES = 16;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } hlcs_req_type;

  typedef struct packed {
    logic        valid;
    logic        tabort;
    logic [31:0] rdata;
  } hlcs_resp_type;

  typedef struct packed {
    logic noswap;
    logic prog;
    logic enh;
    logic link_power_status;
    logic pwe;
    logic le;
  } hlcs_flags_type;

  localparam hlcs_flags_type HLCS_FLAGS_RST = '0;

  typedef struct packed {
    hlcs_flags_type flags;
    logic [20:0]    sidb;
    logic [2:0]     sync;
    logic           phy_ok;
    logic           init_pend;
    logic           online;
    hlcs_resp_type  resp;
  } hlcs_state_type;

  typedef enum logic [1:0] {
    HLCS_SEQ_IDLE = 2'b01,
    HLCS_SEQ_BUSY = 2'b10
  } hlcs_seq_st_type;

  typedef struct packed {
    hlcs_seq_st_type st;
    logic [7:0]      cnt;
    logic            busy;
  } hlcs_seq_type;

  localparam hlcs_seq_type HLCS_SEQ_RST = '{HLCS_SEQ_IDLE, 8'h00, 1'b0};

  // true for offsets clocked by the PHY-supplied clock
  function automatic logic hlcs_in_phy_dom(input logic [11:0] a);
    return ((a >= HLCS_PHY_LO1) && (a <= HLCS_PHY_HI1)) ||
           ((a >= HLCS_PHY_LO2) && (a <= HLCS_PHY_HI2));
  endfunction

endpackage

// ===== src/hlcs_srst_seq.sv
`timescale 1ns/1ns
module hlcs_srst_seq
  import hlcs_pkg::*;
#(
  parameter int unsigned CYCLES = HLCS_SRST_CYCLES
) (
  input  wire logic clk_sys_i, // system clock
  input  wire logic rst_n_i,   // synchronous reset, active low
  input  wire logic start_i,   // one-cycle soft reset request
  output logic      busy_o     // high while soft reset runs
);

  hlcs_seq_type s_reg;
  hlcs_seq_type s_next;

  // count the soft reset length
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      HLCS_SEQ_IDLE: begin
        if (start_i) begin
          s_next.st   = HLCS_SEQ_BUSY;
          s_next.cnt  = 8'(CYCLES - 1);
          s_next.busy = 1'b1;
        end
      end
      HLCS_SEQ_BUSY: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.st   = HLCS_SEQ_IDLE;
          s_next.busy = 1'b0;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      default: begin
        s_next = HLCS_SEQ_RST;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_reg <= HLCS_SEQ_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy_o = s_reg.busy;

endmodule

// ===== src/hlcs_regs.sv
`timescale 1ns/1ns
module hlcs_regs
  import hlcs_pkg::*;
(
  input  wire logic          clk_sys_i,              // system clock
  input  wire logic          rst_n_i,                // sync reset, low
  input  wire hlcs_req_type  req_i,                  // register request
  input  wire logic          phy_supplied_clock_run_i, // PHY clock alive
  input  wire logic          target_abort_disable_i, // config bit 4 at F0h
  input  wire logic          prog_phy_init_i,        // program-PHY strap
  output hlcs_resp_type      resp_o,                 // register answer
  output logic               link_power_status_o,    // link-PHY talk on
  output logic               posted_write_enable_o,  // posting allowed
  output logic               link_enable_o,          // link enable flag
  output logic               link_online_o,          // link on the bus
  output logic               enhancement_enable_o,   // 1394a features on
  output logic               program_phy_perm_o,     // program-PHY flag
  output logic               no_byte_swap_o,         // DMA swap off
  output logic [31:0]        self_id_base_o,         // self-ID buffer base
  output logic               core_reset_o            // soft reset, flush
);

  hlcs_state_type s_reg;
  hlcs_state_type s_next;

  logic        srst_busy;
  logic        srst_start;
  logic [11:0] word_addr;
  logic        wr_ok;
  logic        hit_set;
  logic        hit_clr;
  logic        hit_sidb;
  logic        phy_blocked;
  logic [31:0] ctrl_word;

  // request decode; writes are held off while soft reset runs
  assign word_addr   = {req_i.addr[11:2], 2'b00};
  assign phy_blocked = hlcs_in_phy_dom(word_addr) && !s_reg.phy_ok;
  assign wr_ok       = req_i.valid && req_i.write && !srst_busy &&
                       !phy_blocked;
  assign hit_set     = (word_addr == HLCS_OFS_CTRL_SET);
  assign hit_clr     = (word_addr == HLCS_OFS_CTRL_CLR);
  assign hit_sidb    = (word_addr == HLCS_OFS_SIDB);
  assign srst_start  = wr_ok && hit_set && req_i.wdata[HLCS_BIT_SRST];

  // control word seen through both views, reserved bits zero
  always_comb begin
    ctrl_word                  = 32'h00000000;
    ctrl_word[HLCS_BIT_NOSWAP] = s_reg.flags.noswap;
    ctrl_word[HLCS_BIT_PROG]   = s_reg.flags.prog;
    ctrl_word[HLCS_BIT_ENH]    = s_reg.flags.enh;
    ctrl_word[HLCS_BIT_LPS]    = s_reg.flags.link_power_status;
    ctrl_word[HLCS_BIT_PWE]    = s_reg.flags.pwe;
    ctrl_word[HLCS_BIT_LE]     = s_reg.flags.le;
    ctrl_word[HLCS_BIT_SRST]   = srst_busy;
  end

  // soft reset length counter
  hlcs_srst_seq #(
    .CYCLES (HLCS_SRST_CYCLES)
  ) u_srst (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (srst_start),
    .busy_o    (srst_busy)
  );

  // next state of flags, pointer, synchroniser and answer
  always_comb begin
    s_next      = s_reg;
    s_next.resp = '0;

    // PHY clock status: three stages, change taken when two agree
    s_next.sync = {s_reg.sync[1:0], phy_supplied_clock_run_i};
    if (s_reg.sync[2] == s_reg.sync[1]) begin
      s_next.phy_ok = s_reg.sync[2];
    end

    // program-PHY flag loaded from the strap after reset
    if (s_reg.init_pend) begin
      s_next.flags.prog = prog_phy_init_i;
      s_next.init_pend  = 1'b0;
    end

    // set view: ones set flags except program-PHY, zeros leave them
    if (wr_ok && hit_set) begin
      s_next.flags.noswap = s_reg.flags.noswap |
                            req_i.wdata[HLCS_BIT_NOSWAP];
      s_next.flags.enh    = s_reg.flags.enh |
                            req_i.wdata[HLCS_BIT_ENH];
      s_next.flags.link_power_status    = s_reg.flags.link_power_status |
                            req_i.wdata[HLCS_BIT_LPS];
      s_next.flags.pwe    = s_reg.flags.pwe |
                            req_i.wdata[HLCS_BIT_PWE];
      s_next.flags.le     = s_reg.flags.le |
                            req_i.wdata[HLCS_BIT_LE];
    end

    // clear view: ones clear flags, program-PHY is clear-only
    if (wr_ok && hit_clr) begin
      s_next.flags.noswap = s_reg.flags.noswap &
                            ~req_i.wdata[HLCS_BIT_NOSWAP];
      s_next.flags.prog   = s_next.flags.prog &
                            ~req_i.wdata[HLCS_BIT_PROG];
      s_next.flags.enh    = s_reg.flags.enh &
                            ~req_i.wdata[HLCS_BIT_ENH];
      s_next.flags.link_power_status    = s_reg.flags.link_power_status &
                            ~req_i.wdata[HLCS_BIT_LPS];
      s_next.flags.pwe    = s_reg.flags.pwe &
                            ~req_i.wdata[HLCS_BIT_PWE];
      s_next.flags.le     = s_reg.flags.le &
                            ~req_i.wdata[HLCS_BIT_LE];
    end

    // self-ID base keeps only the aligned upper bits
    if (wr_ok && hit_sidb) begin
      s_next.sidb = req_i.wdata[31:HLCS_SIDB_LSB];
    end

    // soft reset holds every register at its reset value
    if (srst_start || srst_busy) begin
      s_next.flags     = HLCS_FLAGS_RST;
      s_next.sidb      = HLCS_SIDB_RST;
      s_next.init_pend = 1'b1;
    end

    // on the bus only when enabled and the PHY may be reached
    s_next.online = s_next.flags.le && s_next.flags.link_power_status;

    // answer every request one cycle later
    if (req_i.valid) begin
      s_next.resp.valid = 1'b1;
      if (phy_blocked) begin
        if (target_abort_disable_i) begin
          s_next.resp.rdata = HLCS_ALL_ONES;
        end else begin
          s_next.resp.tabort = 1'b1;
        end
      end else if (!req_i.write) begin
        if (hit_set || hit_clr) begin
          s_next.resp.rdata = ctrl_word;
        end else if (hit_sidb) begin
          s_next.resp.rdata = {s_reg.sidb, 11'h000};
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_reg           <= '0;
      s_reg.flags     <= HLCS_FLAGS_RST;
      s_reg.sidb      <= HLCS_SIDB_RST;
      s_reg.init_pend <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign resp_o                = s_reg.resp;
  assign link_power_status_o   = s_reg.flags.link_power_status;
  assign posted_write_enable_o = s_reg.flags.pwe;
  assign link_enable_o         = s_reg.flags.le;
  assign link_online_o         = s_reg.online;
  assign enhancement_enable_o  = s_reg.flags.enh;
  assign program_phy_perm_o    = s_reg.flags.prog;
  assign no_byte_swap_o        = s_reg.flags.noswap;
  assign self_id_base_o        = {s_reg.sidb, 11'h000};
  assign core_reset_o          = srst_busy;

  // checks on the register behaviour
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_rsvd_zero: assert property (
    resp_o.valid && !resp_o.tabort && $past(req_i.valid) &&
    !$past(req_i.write) && $past(hit_set || hit_clr)
    |-> (resp_o.rdata[21:20] == 2'b00) && (resp_o.rdata[29:24] == 6'h00)
  ) else $error("reserved control bits 21:20 not zero");

  a_low_half: assert property (
    resp_o.valid && $past(req_i.valid) && !$past(req_i.write) &&
    $past(hit_clr) |-> resp_o.rdata[15:0] == 16'h0000
  ) else $error("control bits 15:0 not zero");

  a_lps_on: assert property (
    wr_ok && hit_set && req_i.wdata[HLCS_BIT_LPS] && !srst_start
    |=> link_power_status_o
  ) else $error("link power status not set by set view");

  a_lps_gate: assert property (
    !link_power_status_o |-> !link_online_o
  ) else $error("link online while PHY talk blocked");

  a_phy_abort: assert property (
    req_i.valid && phy_blocked && !target_abort_disable_i
    |=> resp_o.valid && resp_o.tabort
  ) else $error("no target abort with PHY clock stopped");

  a_all_ones: assert property (
    req_i.valid && phy_blocked && target_abort_disable_i
    |=> resp_o.valid && !resp_o.tabort && (resp_o.rdata == HLCS_ALL_ONES)
  ) else $error("abort disabled but no all-ones answer");

  a_abort_range: assert property (
    resp_o.tabort |-> $past(hlcs_in_phy_dom(word_addr)) && !$past(s_reg.phy_ok)
  ) else $error("target abort outside PHY clock domain");

  a_pwe_clear: assert property (
    wr_ok && hit_clr && req_i.wdata[HLCS_BIT_PWE]
    |=> !posted_write_enable_o
  ) else $error("posted writes still enabled after clear");

  a_le_reset: assert property (
    srst_start |=> !link_enable_o [*8]
  ) else $error("link enable survived soft reset");

  a_link_off: assert property (
    !link_enable_o |-> !link_online_o
  ) else $error("link online with link enable clear");

  a_srst_flush: assert property (
    srst_start |=> core_reset_o && (self_id_base_o == 32'h00000000) &&
    !enhancement_enable_o && !no_byte_swap_o
  ) else $error("soft reset did not restore registers");

  a_srst_hold: assert property (
    srst_start |-> ##17 !core_reset_o ##0 $past(core_reset_o)
  ) else $error("soft reset length wrong");

  a_srst_read: assert property (
    req_i.valid && !req_i.write && hit_set && srst_busy
    |=> resp_o.rdata[HLCS_BIT_SRST]
  ) else $error("soft reset bit not read as one");

  a_sidb_align: assert property (
    resp_o.valid && !resp_o.tabort && $past(req_i.valid) &&
    !$past(req_i.write) && $past(hit_sidb)
    |-> resp_o.rdata == {$past(self_id_base_o[31:11]), 11'h000}
  ) else $error("self-ID base read not aligned");

  a_sidb_write: assert property (
    wr_ok && hit_sidb && !srst_start
    |=> self_id_base_o == {$past(req_i.wdata[31:11]), 11'h000}
  ) else $error("self-ID base write lost");

  a_set_view: assert property (
    wr_ok && hit_set && req_i.wdata[HLCS_BIT_NOSWAP] && !srst_start
    |=> no_byte_swap_o
  ) else $error("set view did not set flag");

  a_zero_keep: assert property (
    wr_ok && hit_clr && !req_i.wdata[HLCS_BIT_LE] && link_enable_o
    |=> link_enable_o
  ) else $error("zero in clear view changed flag");

  a_prog_no_set: assert property (
    wr_ok && hit_set && req_i.wdata[HLCS_BIT_PROG] && !srst_start &&
    !s_reg.init_pend
    |=> program_phy_perm_o == $past(program_phy_perm_o)
  ) else $error("program-PHY flag set through set view");

  a_srst_wr_drop: assert property (
    req_i.valid && req_i.write && srst_busy
    |=> (self_id_base_o == 32'h00000000) && !link_enable_o
  ) else $error("write took effect during soft reset");

  a_online_on: assert property (
    link_enable_o && link_power_status_o |-> link_online_o
  ) else $error("link offline although enabled and powered");

  a_le_set: assert property (
    wr_ok && hit_set && req_i.wdata[HLCS_BIT_LE] && !srst_start
    |=> link_enable_o
  ) else $error("set view did not set link enable");

  a_le_clear: assert property (
    wr_ok && hit_clr && req_i.wdata[HLCS_BIT_LE]
    |=> !link_enable_o && !link_online_o
  ) else $error("link still on the bus after clear");

  a_pwe_set: assert property (
    wr_ok && hit_set && req_i.wdata[HLCS_BIT_PWE] && !srst_start
    |=> posted_write_enable_o
  ) else $error("posted writes not enabled by set view");

  a_phy_open: assert property (
    req_i.valid && hlcs_in_phy_dom(word_addr) && s_reg.phy_ok
    |=> resp_o.valid && !resp_o.tabort
  ) else $error("target abort with PHY clock running");

  // main scenarios
  c_soft_reset: cover property (srst_start ##17 !core_reset_o);
  c_abort:      cover property (resp_o.valid && resp_o.tabort);
  c_all_ones:   cover property (resp_o.valid && resp_o.rdata == HLCS_ALL_ONES);
  c_online:     cover property (!link_online_o ##1 link_online_o);
  c_pwe_clear:  cover property (wr_ok && hit_clr && req_i.wdata[HLCS_BIT_PWE]);

endmodule

// ===== tb/hlcs_phy_model.sv
`timescale 1ns/1ns
module hlcs_phy_model
  import hlcs_pkg::*;
#(
  parameter int unsigned STABLE_CYCLES = 40
) (
  input  wire logic clk_sys_i,           // system clock
  input  wire logic rst_n_i,             // sync reset, low
  input  wire logic link_power_status_i, // link power request
  output logic      clock_run_o          // PHY clock alive
);
  logic [15:0] cnt_reg;

  // the PHY clock starts only after power is granted and it has settled
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !link_power_status_i) begin
      cnt_reg     <= 16'h0000;
      clock_run_o <= 1'b0;
    end else if (cnt_reg < 16'(STABLE_CYCLES)) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end else begin
      clock_run_o <= 1'b1;
    end
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import hlcs_pkg::*;
  localparam int unsigned STABLE = 40;
  logic          clk_sys_i;
  logic          rst_n_i;
  hlcs_req_type  req;
  hlcs_resp_type resp;
  logic          phy_run;
  logic          tad;
  logic          strap;
  logic          link_power_status, pwe, le, online, enh, prog, nosw, core_rst;
  logic [31:0]   sidb;
  int            err_count;
  int            checks_done;

  hlcs_regs u_hlcs_regs (
    .clk_sys_i                (clk_sys_i),
    .rst_n_i                  (rst_n_i),
    .req_i                    (req),
    .phy_supplied_clock_run_i (phy_run),
    .target_abort_disable_i   (tad),
    .prog_phy_init_i          (strap),
    .resp_o                   (resp),
    .link_power_status_o      (link_power_status),
    .posted_write_enable_o    (pwe),
    .link_enable_o            (le),
    .link_online_o            (online),
    .enhancement_enable_o     (enh),
    .program_phy_perm_o       (prog),
    .no_byte_swap_o           (nosw),
    .self_id_base_o           (sidb),
    .core_reset_o             (core_rst)
  );

  hlcs_phy_model #(.STABLE_CYCLES(STABLE)) u_hlcs_phy_model (
    .clk_sys_i           (clk_sys_i),
    .rst_n_i             (rst_n_i),
    .link_power_status_i (link_power_status),
    .clock_run_o         (phy_run)
  );

  // clock at 250 MHz
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one register access: request for one cycle, wait for the answer
  task automatic acc(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic ab);
    int n;
    @(negedge clk_sys_i);
    req <= '{1'b1, wr, a, d};
    @(negedge clk_sys_i);
    req.valid <= 1'b0;
    n = 0;
    while (resp.valid !== 1'b1 && n < 4) begin
      @(negedge clk_sys_i);
      n++;
    end
    q  = resp.rdata;
    ab = resp.tabort;
    chk(32'(n < 4), 32'h1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        ab;
    acc(1'b0, a, 32'h0, q, ab);
    chk(q, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        ab;
    acc(1'b1, a, d, q, ab);
  endtask

  // phy-domain offsets abort or read all ones while the phy clock is off
  task automatic t_phy_domain();
    logic [31:0] q;
    logic        ab;
    tad = 1'b0;
    acc(1'b0, 12'h0DC, 32'h0, q, ab);
    chk({31'h0, ab}, 32'h1);
    tad = 1'b1;
    acc(1'b0, 12'h11C, 32'h0, q, ab);
    chk({q[30:0], ab}, 32'hFFFFFFFE);
    tad = 1'b0;
    acc(1'b0, 12'h0D8, 32'h0, q, ab);
    chk({31'h0, ab}, 32'h0);
  endtask

  // set and clear views, reserved bits, flag outputs
  task automatic t_set_clear();
    logic [31:0] q;
    logic        ab;
    rd(HLCS_OFS_CTRL_SET, 32'h00800000);
    wr(HLCS_OFS_CTRL_SET, 32'h40040000);
    wr(HLCS_OFS_CTRL_SET, 32'h000A0000);
    chk({31'h0, online}, 32'h1);
    wr(HLCS_OFS_CTRL_SET, 32'h00400000);
    wr(HLCS_OFS_CTRL_SET, 32'hBF30FFFF);
    rd(HLCS_OFS_CTRL_CLR, 32'h40CE0000);
    chk({nosw, prog, enh, link_power_status, pwe, le, online}, 32'h7F);
    // software waits for the phy clock before touching its domain
    repeat (STABLE + 8) @(negedge clk_sys_i);
    acc(1'b0, HLCS_PHY_HI1, 32'h0, q, ab);
    chk({31'h0, ab}, 32'h0);
    wr(HLCS_OFS_CTRL_CLR, 32'h00820000);
    rd(HLCS_OFS_CTRL_SET, 32'h404C0000);
    chk({31'h0, online}, 32'h0);
    wr(HLCS_OFS_CTRL_CLR, 32'h00040000);
    chk({31'h0, pwe}, 32'h0);
    wr(HLCS_OFS_CTRL_SET, 32'h00820000);
    wr(HLCS_OFS_CTRL_CLR, 32'h40000000);
    chk({29'h0, nosw, prog, le}, 32'h1);
  endtask

  task automatic t_self_id();
    wr(HLCS_OFS_SIDB, 32'hFFFFFFFF);
    rd(HLCS_OFS_SIDB, 32'hFFFFF800);
    chk(sidb, 32'hFFFFF800);
    wr(HLCS_OFS_SIDB, 32'h000007FF);
    rd(HLCS_OFS_SIDB, 32'h00000000);
  endtask

  // soft reset runs its full length, clears flags, then self-clears
  task automatic t_soft_reset();
    int n;
    strap = 1'b0;
    wr(HLCS_OFS_CTRL_SET, 32'h00010000);
    chk({31'h0, core_rst}, 32'h1);
    rd(HLCS_OFS_CTRL_SET, 32'h00010000);
    wr(HLCS_OFS_SIDB, 32'hFFFFFFFF);
    chk({le, link_power_status, sidb[31:11]}, 32'h0);
    n = 0;
    while (core_rst === 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(32'(n + 4), 32'(HLCS_SRST_CYCLES));
    rd(HLCS_OFS_CTRL_SET, 32'h00000000);
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    conclude();
  end

  initial begin
    err_count   = 0;
    checks_done = 0;
    rst_n_i     = 1'b0;
    req         = '0;
    tad         = 1'b0;
    strap       = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_phy_domain();
    t_set_clear();
    t_self_id();
    t_soft_reset();
    conclude();
  end
endmodule
